// ===== rtl/bcs_top.sv
// Charge-algorithm sequencer with APB register slave and setpoint outputs.
// Assumes analog comparators deliver asynchronous flags; outputs feed DACs.
//
// Overview of operation
// - Constant current until charge voltage, then hold voltage with falling current.
// - Undervoltage loop lowers charge current to keep input above its minimum.
// - Input current loop limits charge current below programmed input maximum.
// - Both input loops only reduce charge current, never the system load.
// - Li-ion with very low battery precharges first, then full rate.
// - Precharge current is target divided by ten, rounded down.
// - Li-ion ends on time by default, on current when enabled.
// - Phosphate mode may stay in constant voltage with no termination.
// - Absorb phase targets charge voltage plus absorb increment.
// - Absorb ends on voltage reached with low current, or on time limit.
// - After absorb, target returns to charge voltage and charging continues.
// - Temperature profile overrides charge current and voltage targets.
// - Input near battery sense voltage returns any state to suspended.
// - Writing one to halt bit suspends from any state.
// - Any system fault forces the suspended state.
// - Each cycle starts with a timed detection test drawing a small load.
// - Stable battery goes to soft-start, otherwise to open/short test.
// - Open/short test charges at minimum current, passes only if in range.
// - Open or very high thermistor resistance declares battery open fault.
// - Maskable alert signals that a detection fault occurred.
// - Soft-start ramps current setpoint one step per fixed interval.
`timescale 1ns/1ps
`default_nettype none

module bcs_top #(
	parameter int unsigned SOFT_CYC = bcs_pkg::SOFT_STEP_CYC,
	parameter int unsigned SEC_CYC = bcs_pkg::SEC_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire bcs_pkg::bcs_sense_s sense_in,
	input wire bcs_pkg::bcs_fault_s fault_in,
	output bcs_pkg::bcs_drive_s drive,
	output logic alert
);
	import bcs_pkg::*;

	localparam int SW = $clog2(SOFT_CYC + 1);
	localparam int TW = $clog2(SEC_CYC + 1);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers: the first stage feeds only the second
	bcs_sense_s sense_m_q, sense_q;
	bcs_fault_s fault_m_q, fault_q;

	always_ff @(posedge ref_clk) begin
		sense_m_q <= sense_in;
		sense_q <= sense_m_q;
		fault_m_q <= fault_in;
		fault_q <= fault_m_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [CTRL_W-1:0] ctrl_q;
	logic [4:0] chg_i_q, chg_v_q, vinc_q, temp_i_q, temp_v_q;
	logic [15:0] cv_time_q, abs_time_q;
	logic dfault_q;
	bcs_state_e st_q, st_d;

	// APB decode; access completes on the second access cycle
	logic acc, wr_go, rd_go, hit;
	assign acc = psel && penable && !pready;
	assign wr_go = psel && penable && pready && pwrite;
	assign rd_go = acc && !pwrite;
	assign hit = (paddr[1:0] == 2'b00) && (paddr <= OFS_EVENT);

	// Read multiplexer
	logic [31:0] rd_val;
	always_comb begin
		case (paddr)
			OFS_CTRL: rd_val = {26'h0, ctrl_q};
			OFS_CHG_I: rd_val = {27'h0, chg_i_q};
			OFS_CHG_V: rd_val = {19'h0, vinc_q, 3'h0, chg_v_q};
			OFS_CV_TIME: rd_val = {16'h0, cv_time_q};
			OFS_ABS_TIME: rd_val = {16'h0, abs_time_q};
			OFS_TEMP: rd_val = {19'h0, temp_v_q, 3'h0, temp_i_q};
			OFS_STATUS: rd_val = {21'h0, sense_q.icl_trip, sense_q.uvcl_trip,
				dfault_q, 4'h0, st_q};
			OFS_EVENT: rd_val = {31'h0, dfault_q};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Bus answer: one wait state, error for unmapped words
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= acc;
			pslverr <= acc && !hit;
			if (rd_go) begin
				prdata <= hit ? rd_val : 32'h0000_0000;
			end
		end
	end

	// Software writes; a write to a read-only or unmapped word is dropped
	logic wr_ok;
	assign wr_ok = wr_go && hit;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_q <= CTRL_RST;
			chg_i_q <= CHG_I_RST;
			chg_v_q <= CHG_V_RST;
			vinc_q <= VINC_RST;
			cv_time_q <= CV_TIME_RST;
			abs_time_q <= ABS_TIME_RST;
			temp_i_q <= CHG_I_RST;
			temp_v_q <= CHG_V_RST;
		end else if (wr_ok) begin
			case (paddr)
				OFS_CTRL: ctrl_q <= pwdata[CTRL_W-1:0];
				OFS_CHG_I: chg_i_q <= pwdata[4:0];
				OFS_CHG_V: begin
					chg_v_q <= pwdata[4:0];
					vinc_q <= pwdata[VINC_LSB+4:VINC_LSB];
				end
				OFS_CV_TIME: cv_time_q <= pwdata[15:0];
				OFS_ABS_TIME: abs_time_q <= pwdata[15:0];
				OFS_TEMP: begin
					temp_i_q <= pwdata[4:0];
					temp_v_q <= pwdata[VINC_LSB+4:VINC_LSB];
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Effective targets
	logic [4:0] tgt_i, tgt_v, pre_i;
	logic [5:0] abs_v;
	logic phos, abs_on;
	assign tgt_i = ctrl_q[CTRL_TEMP] ? temp_i_q : chg_i_q;
	assign tgt_v = ctrl_q[CTRL_TEMP] ? temp_v_q : chg_v_q;
	assign pre_i = tgt_i / PRE_DIV;
	assign abs_v = {1'b0, tgt_v} + {1'b0, vinc_q};
	assign phos = ctrl_q[CTRL_PHOS];
	assign abs_on = phos && (vinc_q != 5'h00);

	// Suspend conditions apply in every state
	logic sys_fault, susp_req;
	assign sys_fault = |fault_q;
	assign susp_req = sys_fault || sense_q.vin_near_bat || ctrl_q[CTRL_HALT];

	////////////////////////////////////////////////////////////////////////////////
	// State timers restart whenever the state changes
	logic restart;
	logic [TW-1:0] cyc_q;
	logic [15:0] sec_q;
	logic [SW-1:0] step_q;
	logic [4:0] ramp_q;
	logic sec_tick, step_tick;
	assign restart = (st_d != st_q);
	assign sec_tick = (cyc_q == TW'(SEC_CYC - 1));
	assign step_tick = (step_q == SW'(SOFT_CYC - 1));

	// Seconds counter, saturating
	always_ff @(posedge ref_clk) begin
		if (!rst_n || restart) begin
			cyc_q <= '0;
			sec_q <= 16'h0000;
		end else if (sec_tick) begin
			cyc_q <= '0;
			sec_q <= (sec_q == 16'hFFFF) ? sec_q : sec_q + 16'h0001;
		end else begin
			cyc_q <= cyc_q + TW'(1);
		end
	end

	// Soft-start ramp: one setpoint step per interval
	always_ff @(posedge ref_clk) begin
		if (!rst_n || restart) begin
			step_q <= '0;
			ramp_q <= 5'h00;
		end else if (st_q == ST_SOFT) begin
			step_q <= step_tick ? '0 : step_q + SW'(1);
			if (step_tick && ramp_q < tgt_i) begin
				ramp_q <= ramp_q + 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer next state
	logic det_done, ost_done, cv_done, abs_done;
	assign det_done = sec_q >= 16'(DET_S);
	assign ost_done = sec_q >= 16'(OST_S);
	assign cv_done = sec_q >= cv_time_q;
	assign abs_done = (sense_q.bat_at_v && sense_q.ibat_below_cx)
		|| (sec_q >= abs_time_q);

	// Where soft-start hands over
	bcs_state_e after_soft;
	assign after_soft = (!phos && sense_q.bat_low) ? ST_PRE :
		abs_on ? ST_ABS : ST_CC;

	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_SUSP: st_d = ST_DET;
			ST_DET: begin
				if (sense_q.ntc_open) begin
					st_d = ST_DFLT;
				end else if (det_done) begin
					st_d = sense_q.bat_stable ? ST_SOFT : ST_OST;
				end
			end
			ST_OST: begin
				if (ost_done) begin
					st_d = sense_q.bat_in_range ? ST_SOFT : ST_DFLT;
				end
			end
			ST_SOFT: begin
				if (ramp_q >= tgt_i) begin
					st_d = after_soft;
				end
			end
			ST_PRE: begin
				if (!sense_q.bat_low) begin
					st_d = ST_CC;
				end
			end
			ST_ABS: begin
				if (abs_done) begin
					st_d = ST_CC;
				end
			end
			ST_CC: begin
				if (sense_q.bat_at_v) begin
					st_d = ST_CV;
				end
			end
			ST_CV: begin
				if (phos && ctrl_q[CTRL_NOTERM]) begin
					st_d = ST_CV;
				end else if (ctrl_q[CTRL_CTERM]) begin
					if (sense_q.ibat_below_cx) begin
						st_d = ST_TERM;
					end
				end else if (cv_done) begin
					st_d = ST_TERM;
				end
			end
			ST_TERM: st_d = ST_TERM;
			ST_DFLT: st_d = ST_DFLT;
			default: st_d = ST_SUSP;
		endcase
		if (susp_req) begin
			st_d = ST_SUSP;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_q <= ST_SUSP;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Detection fault flag and alert; a new fault beats a clear in the same cycle
	logic df_set, df_clr;
	assign df_set = (st_d == ST_DFLT) && (st_q != ST_DFLT);
	assign df_clr = wr_ok && (paddr == OFS_EVENT) && pwdata[0];
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dfault_q <= 1'b0;
			alert <= 1'b0;
		end else begin
			dfault_q <= df_set || (dfault_q && !df_clr);
			alert <= ctrl_q[CTRL_ALERT_EN] && (df_set || (dfault_q && !df_clr));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input limit loops trim a ceiling on the charge setpoint only; the
	// system load path is never touched, so the load keeps priority.
	logic [4:0] lim_q;
	logic trip;
	assign trip = sense_q.uvcl_trip || sense_q.icl_trip;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lim_q <= 5'h1F;
		end else if (step_tick || st_q != ST_SOFT) begin
			if (trip && lim_q != 5'h00) begin
				lim_q <= lim_q - 5'h01;
			end else if (!trip && lim_q != 5'h1F) begin
				lim_q <= lim_q + 5'h01;
			end
		end
	end

	// Setpoint selection per state
	logic [4:0] i_raw, i_cmd;
	logic [5:0] v_cmd;
	always_comb begin
		case (st_q)
			ST_OST: i_raw = OST_I;
			ST_SOFT: i_raw = ramp_q;
			ST_PRE: i_raw = pre_i;
			ST_ABS, ST_CC, ST_CV: i_raw = tgt_i;
			default: i_raw = 5'h00;
		endcase
	end
	assign i_cmd = (i_raw > lim_q) ? lim_q : i_raw;
	assign v_cmd = (st_q == ST_ABS) ? abs_v : {1'b0, tgt_v};

	// Drive register toward the analog loops
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			drive <= '0;
		end else begin
			drive.detect_load <= (st_d == ST_DET);
			drive.i_set <= i_cmd;
			drive.v_set <= v_cmd;
		end
	end

endmodule

`default_nettype wire

// ===== rtl/bcs_pkg.sv
// Shared constants, register map, states and carriers of the charge sequencer.
// Assumes a single 25 MHz clock and an APB master with 32-bit data.
package bcs_pkg;

	// Clock rate and derived timing counts
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned SOFT_STEP_US = 400;
	localparam int unsigned SOFT_STEP_CYC = CLK_HZ / 1_000_000 * SOFT_STEP_US;
	localparam int unsigned SEC_S = 1;
	localparam int unsigned SEC_CYC = CLK_HZ * SEC_S;
	localparam int unsigned DET_S = 3;
	localparam int unsigned OST_S = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CHG_I = 8'h04;
	localparam logic [7:0] OFS_CHG_V = 8'h08;
	localparam logic [7:0] OFS_CV_TIME = 8'h0C;
	localparam logic [7:0] OFS_ABS_TIME = 8'h10;
	localparam logic [7:0] OFS_TEMP = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_EVENT = 8'h1C;

	// Control register bit positions
	localparam int unsigned CTRL_HALT = 0;
	localparam int unsigned CTRL_TEMP = 1;
	localparam int unsigned CTRL_CTERM = 2;
	localparam int unsigned CTRL_NOTERM = 3;
	localparam int unsigned CTRL_PHOS = 4;
	localparam int unsigned CTRL_ALERT_EN = 5;
	localparam int unsigned CTRL_W = 6;

	// Field positions in voltage, temperature and status words
	localparam int unsigned VINC_LSB = 8;
	localparam int unsigned ST_FAULT = 8;
	localparam int unsigned ST_UVCL = 9;
	localparam int unsigned ST_ICL = 10;

	// Reset values, precharge divisor and open/short test current
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	localparam logic [4:0] CHG_I_RST = 5'h1F;
	localparam logic [4:0] CHG_V_RST = 5'h1F;
	localparam logic [4:0] VINC_RST = 5'h00;
	localparam logic [15:0] CV_TIME_RST = 16'h3840;
	localparam logic [15:0] ABS_TIME_RST = 16'h0384;
	localparam logic [4:0] PRE_DIV = 5'h0A;
	localparam logic [4:0] OST_I = 5'h01;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_SUSP = 4'h0,
		ST_DET = 4'h1,
		ST_OST = 4'h2,
		ST_SOFT = 4'h3,
		ST_PRE = 4'h4,
		ST_ABS = 4'h5,
		ST_CC = 4'h6,
		ST_CV = 4'h7,
		ST_TERM = 4'h8,
		ST_DFLT = 4'h9
	} bcs_state_e;

	// Comparator flags from the analog side
	typedef struct packed {
		logic vin_near_bat;
		logic bat_stable;
		logic bat_in_range;
		logic bat_low;
		logic bat_at_v;
		logic ibat_below_cx;
		logic ntc_open;
		logic uvcl_trip;
		logic icl_trip;
	} bcs_sense_s;

	// System fault flags
	typedef struct packed {
		logic vin_ov;
		logic supply_uv;
		logic therm_sd;
		logic rt_missing;
		logic cells_bad;
	} bcs_fault_s;

	// Setpoints toward the charge loops
	typedef struct packed {
		logic detect_load;
		logic [4:0] i_set;
		logic [5:0] v_set;
	} bcs_drive_s;

endpackage

// ===== verification/bcs_checker_assertions.sv
// Concurrent checks on the charge sequencer top ports.
// Assumes one clock, a synchronous active-low reset and short timing parameters.
`timescale 1ns/1ps
`default_nettype none
module bcs_checker import bcs_pkg::*; #(
	parameter int unsigned SOFT_CYC = 4,
	parameter int unsigned SEC_CYC = 16
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire bcs_pkg::bcs_sense_s sense_in,
	input wire bcs_pkg::bcs_fault_s fault_in,
	input wire bcs_pkg::bcs_drive_s drive
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [31:0] det_cnt_q;
	logic [31:0] det_cnt_d;

	////////////////////////////////////////////////////////////////////////////////
	// Length of the detection load, so a stuck timer shows up as an overrun
	assign det_cnt_d = drive.detect_load ? det_cnt_q + 32'h0000_0001 : 32'h0000_0000;
	always_ff @(posedge ref_clk) begin
		det_cnt_q <= rst_n ? det_cnt_d : 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Halt write lands, state drops next edge, setpoints register one edge later
	property p_halt;
		psel && penable && pready && pwrite && paddr == OFS_CTRL && pwdata[CTRL_HALT]
			|-> ##3 (drive.i_set == 5'h00 && !drive.detect_load);
	endproperty
	a_halt: assert property (p_halt) else $error("halt did not stop charging");
	// Margin covers the two-stage input synchroniser
	property p_fault;
		(fault_in != 5'h00) [*5] |=> drive.i_set == 5'h00;
	endproperty
	a_fault: assert property (p_fault) else $error("fault did not stop charging");
	property p_vin;
		sense_in.vin_near_bat [*5] |=> (drive.i_set == 5'h00 && !drive.detect_load);
	endproperty
	a_vin: assert property (p_vin) else $error("low headroom did not suspend");
	property p_det;
		det_cnt_q <= DET_S * SEC_CYC + 2;
	endproperty
	a_det: assert property (p_det) else $error("detection load held too long");
	property p_ntc;
		(sense_in.ntc_open && drive.detect_load) ##1 sense_in.ntc_open [*3]
			|=> !drive.detect_load;
	endproperty
	a_ntc: assert property (p_ntc) else $error("open thermistor not faulted");
	property p_step;
		$past(drive.i_set) == 5'h00 && drive.i_set != 5'h00 |-> drive.i_set == 5'h01;
	endproperty
	a_step: assert property (p_step) else $error("current left zero by more than one step");
	property p_rdy;
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("bus answer not a single pulse");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("error flag outside answer");
endmodule
`default_nettype wire

// ===== verification/bcs_batt_model.sv
// Battery and power stage stand-in feeding the comparator flags.
// Assumes the bench sets the battery condition knobs through cmd.
`timescale 1ns/1ps
`default_nettype none
module bcs_batt_model import bcs_pkg::*; (
	input wire bcs_pkg::bcs_drive_s drive,
	input wire bcs_pkg::bcs_sense_s cmd,
	output bcs_pkg::bcs_sense_s sense_in
);
	// A pack only proves its range while current flows into it
	always_comb begin
		sense_in = cmd;
		sense_in.bat_in_range = cmd.bat_in_range && (drive.i_set != 5'h00);
	end
endmodule
`default_nettype wire

// ===== verification/battery_charge_sequencer_tb.sv
// Self-checking bench for the charge sequencer, driven over APB.
// Assumes short timing parameters: 4 cycles per ramp step, 16 per second.
`timescale 1ns/1ps
`default_nettype none
module battery_charge_sequencer_tb;
	import bcs_pkg::*;
	localparam int unsigned SOFT_T = 4;
	localparam int unsigned SEC_T = 16;
	logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, alert, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	bcs_sense_s cmd, sense_in;
	bcs_fault_s fault_in;
	bcs_drive_s drive;
	int num_errors, n_checks;
	logic [31:0] rst_tab [6] = '{32'h0000_0000, 32'h0000_001F, 32'h0000_001F,
		32'h0000_3840, 32'h0000_0384, 32'h0000_1F1F};

	bcs_top #(.SOFT_CYC(SOFT_T), .SEC_CYC(SEC_T)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_in(sense_in),
		.fault_in(fault_in), .drive(drive), .alert(alert));
	bcs_batt_model u_batt (.drive(drive), .cmd(cmd), .sense_in(sense_in));

	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop();
		num_errors++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		close_out();
	endtask
	// One transfer; signals are sampled before the edge's own updates land
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) stop();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Poll the state field; a lost sequence ends the run
	task automatic wait_st(input bcs_state_e s);
		int n;
		n = 0;
		rd = 32'h0000_000F;
		while (rd[3:0] !== s && n < 200) begin
			apb(1'b0, OFS_STATUS, 32'h0000_0000);
			n++;
		end
		if (rd[3:0] !== s) stop();
		n_checks++;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		fault_in = 5'h00;
		cmd = '0;
		cmd.bat_stable = 1'b1;
		cmd.bat_low = 1'b1;
		num_errors = 0;
		n_checks = 0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		apb(1'b1, OFS_CV_TIME, 32'h0000_0002);
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0000_0000);
			// The seconds limit was rewritten to 2 just before this sweep
			chk(rd, (i == 3) ? 32'h0000_0002 : rst_tab[i]);
		end
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		apb(1'b1, OFS_CHG_I, 32'h0000_0017);
		wait_st(ST_PRE);
		chk(32'(drive.i_set), 32'(5'd23 / 5'd10));
		cmd.bat_low <= 1'b0;
		wait_st(ST_CC);
		chk(32'(drive), {20'h0, 1'b0, 5'd23, 6'h1F});
		apb(1'b1, OFS_TEMP, 32'h0000_0A07);
		apb(1'b1, OFS_CTRL, 32'h0000_0002);
		// Setpoints register one edge after the control word lands
		@(posedge ref_clk);
		chk(32'(drive), {20'h0, 1'b0, 5'd7, 6'h0A});
		cmd.bat_at_v <= 1'b1;
		wait_st(ST_CV);
		wait_st(ST_TERM);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		// State drops one edge after the write, setpoints one edge later
		repeat (2) @(posedge ref_clk);
		// Current collapses; voltage falls back to the plain charge setting
		chk(32'(drive), 32'h0000_001F);
		// Phosphate with absorb, ended by low current, then current termination
		cmd.bat_at_v <= 1'b0;
		apb(1'b1, OFS_CHG_V, 32'h0000_0310);
		apb(1'b1, OFS_CTRL, 32'h0000_0014);
		wait_st(ST_ABS);
		chk(32'(drive.v_set), 32'h0000_0013);
		cmd.bat_at_v <= 1'b1;
		cmd.ibat_below_cx <= 1'b1;
		wait_st(ST_TERM);
		chk(32'(drive.v_set), 32'h0000_0010);
		apb(1'b1, OFS_CTRL, 32'h0000_0019);
		apb(1'b1, OFS_CTRL, 32'h0000_0018);
		wait_st(ST_CV);
		repeat (4 * SEC_T) @(posedge ref_clk);
		wait_st(ST_CV);
		fault_in <= 5'h04;
		wait_st(ST_SUSP);
		fault_in <= 5'h00;
		// Let the cycle restart before pulling the input down to the pack
		wait_st(ST_DET);
		cmd.vin_near_bat <= 1'b1;
		wait_st(ST_SUSP);
		// Failed detection, then the open/short test fails too
		cmd.vin_near_bat <= 1'b0;
		cmd.bat_stable <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h0000_0020);
		wait_st(ST_OST);
		chk(32'(drive.i_set), 32'h0000_0001);
		wait_st(ST_DFLT);
		chk(32'(alert), 32'h0000_0001);
		apb(1'b1, OFS_EVENT, 32'h0000_0001);
		chk(32'(alert), 32'h0000_0000);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		cmd.bat_stable <= 1'b1;
		cmd.ntc_open <= 1'b1;
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		wait_st(ST_DFLT);
		apb(1'b0, OFS_EVENT, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		chk(32'(alert), 32'h0000_0000);
		close_out();
	end
endmodule

bind bcs_top bcs_checker #(.SOFT_CYC(SOFT_CYC), .SEC_CYC(SEC_CYC)) u_chk (.ref_clk(ref_clk),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .sense_in(sense_in),
	.fault_in(fault_in), .drive(drive));
`default_nettype wire
